// ### hdl/scdac_top.sv
// Control logic of the two-stage switched capacitor voltage converter
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "scdac_consts.svh"
module scdac_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] col_clk_src,
   output scdac_pkg::scdac_analog_t analog_ctl,
   output logic cpu_clk_hold
);
   import scdac_pkg::*;

   // Software-visible control fields
   typedef struct packed {
      logic phase_order_select;
      logic output_bus_route_enable;
      logic stall_sync_control;
      logic [1:0] col_clk_select;
      scdac_fmt_t input_code_format;
      scdac_power_t power_level;
   } scdac_ctrl_t;

   // Whole state of this module
   typedef struct packed {
      scdac_ctrl_t ctrl;
      logic [7:0] pending_code;
      logic [7:0] active_code;
      logic written;
      logic [7:0] update_count;
      logic [31:0] rdata;
      logic slverr;
      scdac_analog_t ana;
   } scdac_top_state_t;

   scdac_top_state_t st_reg;
   scdac_top_state_t st_next;
   scdac_phase_t phase;
   logic col_clk_level;
   logic stall_req;
   logic access_ok;
   logic stall_active;
   logic setup_phase;
   logic access_phase;
   logic wr_commit;
   logic [7:0] wr_code;

   // Address decode used by both read and write paths
   function automatic logic is_mapped(input logic [11:0] addr);
      is_mapped = (addr == `SCDAC_CTRL_OFS) ||
                  (addr == `SCDAC_VALUE_OFS) ||
                  (addr == `SCDAC_STATUS_OFS);
   endfunction : is_mapped

   function automatic logic is_value(input logic [11:0] addr);
      is_value = (addr == `SCDAC_VALUE_OFS);
   endfunction : is_value

   // Input code to internal sign and 7-bit magnitude
   function automatic logic [7:0] to_sign_mag(input logic [7:0] code,
                                              input scdac_fmt_t fmt);
      logic [8:0] sval;
      logic [8:0] mag;
      sval = 9'h000;
      mag = 9'h000;
      case (fmt)
         FMT_TWOS: begin
            sval = {code[7], code};
         end
         FMT_OFFSET_BIN: begin
            sval = {1'b0, code} - 9'h07f;
         end
         default: begin
            sval = 9'h000;
         end
      endcase
      mag = sval[8] ? (9'h000 - sval) : sval;
      if (mag > {2'h0, `SCDAC_MAG_MAX}) begin
         mag = {2'h0, `SCDAC_MAG_MAX};
      end
      if (fmt == FMT_SIGN_MAG || fmt == FMT_SPARE) begin
         to_sign_mag = code;
      end else begin
         to_sign_mag = {sval[8] && (mag != 9'h000), mag[6:0]};
      end
   endfunction : to_sign_mag

   // One column clock source feeds both stages
   assign col_clk_level = col_clk_src[st_reg.ctrl.col_clk_select];

   scdac_phase_gen u_phase (
      .pclk(pclk),
      .presetn(presetn),
      .col_clk_level(col_clk_level),
      .phase(phase)
   );

   // Bus phases and the stalled value write
   assign setup_phase = psel && !penable;
   assign access_phase = psel && penable;
   assign stall_req = access_phase && pwrite && is_value(paddr) &&
                      st_reg.ctrl.stall_sync_control;

   scdac_stall_sync u_stall (
      .pclk(pclk),
      .presetn(presetn),
      .stall_req(stall_req),
      .cycle_start(phase.cycle_start),
      .access_ok(access_ok),
      .stall_active(stall_active),
      .cpu_clk_hold(cpu_clk_hold)
   );

   assign wr_commit = access_phase && pwrite && access_ok;
   assign wr_code = to_sign_mag(pwdata[7:0], st_reg.ctrl.input_code_format);

   // Register writes, update cycle and analog controls
   always_comb begin
      st_next = st_reg;
      // Register writes take effect at the completing edge
      if (wr_commit && !st_reg.slverr) begin
         case (paddr)
            `SCDAC_CTRL_OFS: begin
               st_next.ctrl.phase_order_select =
                  pwdata[`SCDAC_CTRL_PHASE_BIT];
               st_next.ctrl.output_bus_route_enable =
                  pwdata[`SCDAC_CTRL_ROUTE_BIT];
               st_next.ctrl.stall_sync_control =
                  pwdata[`SCDAC_CTRL_STALL_BIT];
               st_next.ctrl.col_clk_select =
                  pwdata[`SCDAC_CTRL_CLKSEL_LSB +: 2];
               st_next.ctrl.input_code_format =
                  scdac_fmt_t'(pwdata[`SCDAC_CTRL_FMT_LSB +: 2]);
               st_next.ctrl.power_level =
                  scdac_power_t'(pwdata[`SCDAC_CTRL_PWR_LSB +: 2]);
            end
            `SCDAC_VALUE_OFS: begin
               st_next.pending_code = wr_code;
               st_next.written = 1'b1;
            end
            default: begin
               st_next.written = st_reg.written;
            end
         endcase
      end
      // Every cycle reloads the stage, new value or not
      if (phase.cycle_start) begin
         st_next.update_count = st_reg.update_count + 8'h01;
         if (wr_commit && is_value(paddr)) begin
            st_next.active_code = wr_code;
         end else begin
            st_next.active_code = st_reg.pending_code;
         end
      end
      // Read data captured in the setup cycle
      if (setup_phase) begin
         st_next.slverr = !is_mapped(paddr);
         st_next.rdata = 32'h0000_0000;
         case (paddr)
            `SCDAC_CTRL_OFS: begin
               st_next.rdata[`SCDAC_CTRL_PHASE_BIT] =
                  st_reg.ctrl.phase_order_select;
               st_next.rdata[`SCDAC_CTRL_ROUTE_BIT] =
                  st_reg.ctrl.output_bus_route_enable;
               st_next.rdata[`SCDAC_CTRL_STALL_BIT] =
                  st_reg.ctrl.stall_sync_control;
               st_next.rdata[`SCDAC_CTRL_CLKSEL_LSB +: 2] =
                  st_reg.ctrl.col_clk_select;
               st_next.rdata[`SCDAC_CTRL_FMT_LSB +: 2] =
                  st_reg.ctrl.input_code_format;
               st_next.rdata[`SCDAC_CTRL_PWR_LSB +: 2] =
                  st_reg.ctrl.power_level;
            end
            `SCDAC_VALUE_OFS: begin
               st_next.rdata[7:0] = st_reg.pending_code;
            end
            `SCDAC_STATUS_OFS: begin
               st_next.rdata[`SCDAC_STAT_PHI1_BIT] = phase.phi1;
               st_next.rdata[`SCDAC_STAT_PHI2_BIT] = phase.phi2;
               st_next.rdata[`SCDAC_STAT_PWR_BIT] =
                  st_reg.ana.outputs_driven;
               st_next.rdata[`SCDAC_STAT_STALL_BIT] = stall_active;
               st_next.rdata[`SCDAC_STAT_WRITTEN_BIT] = st_reg.written;
               st_next.rdata[`SCDAC_STAT_CODE_LSB +: 8] = st_reg.active_code;
               st_next.rdata[`SCDAC_STAT_PEND_LSB +: 8] =
                  st_reg.pending_code;
               st_next.rdata[`SCDAC_STAT_CNT_LSB +: 8] = st_reg.update_count;
            end
            default: begin
               st_next.rdata = 32'h0000_0000;
            end
         endcase
      end
      // Phase clocks to the analog switches
      st_next.ana.phi1 = phase.phi1;
      st_next.ana.phi2 = phase.phi2;
      if (st_reg.ctrl.phase_order_select) begin
         st_next.ana.autozero = phase.phi2;
         st_next.ana.output_valid = phase.phi1;
         st_next.ana.sh_switch_closed = 1'b1;
      end else begin
         st_next.ana.autozero = phase.phi1;
         st_next.ana.output_valid = phase.phi2;
         st_next.ana.sh_switch_closed = phase.sample_window;
      end
      // Bus routing and the off-chip buffer
      st_next.ana.output_bus_route_enable =
         st_reg.ctrl.output_bus_route_enable;
      st_next.ana.out_buffer_enable =
         st_reg.ctrl.output_bus_route_enable &&
         (st_reg.ctrl.power_level != power_level_off);
      // Stage power; outputs driven whenever not off
      st_next.ana.stage_power = st_reg.ctrl.power_level;
      st_next.ana.outputs_driven =
         (st_reg.ctrl.power_level != power_level_off);
      // Magnitude split: low bits to the low stage feeding the high one
      st_next.ana.sign_negative = st_reg.active_code[7];
      st_next.ana.msb_magnitude = st_reg.active_code[6:2];
      st_next.ana.lsb_magnitude = st_reg.active_code[1:0];
   end

   // State register; ground code and power off at reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
         st_reg.ctrl <= scdac_ctrl_t'(9'(`SCDAC_CTRL_RST));
         st_reg.pending_code <= `SCDAC_VALUE_RST;
         st_reg.active_code <= `SCDAC_VALUE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // Bus answers; ready is held low only by a synchronised write
   assign pready = access_ok;
   assign pslverr = access_phase && st_reg.slverr;
   assign prdata = st_reg.rdata;
   assign analog_ctl = st_reg.ana;

endmodule : scdac_top

// ### hdl/scdac_consts.svh
// Offsets, field positions, reset values and phase timing of the converter
`ifndef SCDAC_CONSTS_SVH
`define SCDAC_CONSTS_SVH

// Register byte offsets
`define SCDAC_CTRL_OFS 12'h000
`define SCDAC_VALUE_OFS 12'h004
`define SCDAC_STATUS_OFS 12'h008

// Control register field positions
`define SCDAC_CTRL_PHASE_BIT 0
`define SCDAC_CTRL_ROUTE_BIT 1
`define SCDAC_CTRL_STALL_BIT 2
`define SCDAC_CTRL_CLKSEL_LSB 4
`define SCDAC_CTRL_FMT_LSB 8
`define SCDAC_CTRL_PWR_LSB 12

// Status register field positions
`define SCDAC_STAT_PHI1_BIT 0
`define SCDAC_STAT_PHI2_BIT 1
`define SCDAC_STAT_PWR_BIT 2
`define SCDAC_STAT_STALL_BIT 3
`define SCDAC_STAT_WRITTEN_BIT 4
`define SCDAC_STAT_CODE_LSB 8
`define SCDAC_STAT_PEND_LSB 16
`define SCDAC_STAT_CNT_LSB 24

// Reset values; code 8'h00 is analog ground
`define SCDAC_CTRL_RST 32'h0000_0000
`define SCDAC_VALUE_RST 8'h00

// Column clock periods per update cycle, and phase steps in half periods
`define SCDAC_COL_DIVIDE 4
`define SCDAC_STEP_LAST 3'h7
`define SCDAC_PHI1_STEP_A 3'h0
`define SCDAC_PHI1_STEP_B 3'h1
`define SCDAC_PHI2_STEP_A 3'h4
`define SCDAC_PHI2_STEP_B 3'h5
`define SCDAC_MAG_MAX 7'h7f

`endif

// ### hdl/scdac_pkg.sv
// Types shared by the converter control blocks
package scdac_pkg;

   typedef enum logic [1:0] {
      power_level_off = 2'h0,
      power_level_low = 2'h1,
      power_level_medium = 2'h2,
      power_level_full = 2'h3
   } scdac_power_t;

   typedef enum logic [1:0] {
      FMT_SIGN_MAG = 2'h0,
      FMT_TWOS = 2'h1,
      FMT_OFFSET_BIN = 2'h2,
      FMT_SPARE = 2'h3
   } scdac_fmt_t;

   typedef enum logic [1:0] {
      STALL_IDLE = 2'h1,
      STALL_WAIT = 2'h2
   } scdac_stall_st_t;

   // Phase clocks and timing strobes from the divider
   typedef struct packed {
      logic phi1;
      logic phi2;
      logic sample_window;
      logic cycle_start;
   } scdac_phase_t;

   // Switch and stage controls towards the analog array
   typedef struct packed {
      logic phi1;
      logic phi2;
      logic autozero;
      logic output_valid;
      logic sh_switch_closed;
      logic output_bus_route_enable;
      logic out_buffer_enable;
      scdac_power_t stage_power;
      logic outputs_driven;
      logic sign_negative;
      logic [4:0] msb_magnitude;
      logic [1:0] lsb_magnitude;
   } scdac_analog_t;

endpackage : scdac_pkg

// ### hdl/scdac_phase_gen.sv
// Column clock divider producing the two non-overlapping phase clocks
`timescale 1ns/10ps
`include "scdac_consts.svh"
module scdac_phase_gen (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic col_clk_level,
   output scdac_pkg::scdac_phase_t phase
);
   import scdac_pkg::*;

   typedef struct packed {
      logic prev_level;
      logic [2:0] step;
   } scdac_pg_state_t;

   scdac_pg_state_t st_reg;
   scdac_pg_state_t st_next;
   logic col_edge;

   // Each column clock edge advances one half period
   always_comb begin
      st_next = st_reg;
      col_edge = col_clk_level ^ st_reg.prev_level;
      st_next.prev_level = col_clk_level;
      if (col_edge) begin
         st_next.step = st_reg.step + 3'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Four column periods: phi1 first, phi2 third, gaps between
   always_comb begin
      phase.phi1 = (st_reg.step == `SCDAC_PHI1_STEP_A) ||
                   (st_reg.step == `SCDAC_PHI1_STEP_B);
      phase.phi2 = (st_reg.step == `SCDAC_PHI2_STEP_A) ||
                   (st_reg.step == `SCDAC_PHI2_STEP_B);
      phase.sample_window = (st_reg.step == `SCDAC_PHI2_STEP_B);
      phase.cycle_start = col_edge &&
                          (st_reg.step == `SCDAC_STEP_LAST);
   end

endmodule : scdac_phase_gen

// ### hdl/scdac_stall_sync.sv
// Holds a synchronised value write until the next phi1 rising edge
`timescale 1ns/10ps
module scdac_stall_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic stall_req,
   input wire logic cycle_start,
   output logic access_ok,
   output logic stall_active,
   output logic cpu_clk_hold
);
   import scdac_pkg::*;

   typedef struct packed {
      scdac_stall_st_t state;
   } scdac_ss_state_t;

   scdac_ss_state_t st_reg;
   scdac_ss_state_t st_next;

   // Wait state follows the held access until phi1 begins
   always_comb begin
      st_next = st_reg;
      case (st_reg.state)
         STALL_IDLE: begin
            if (stall_req && !cycle_start) begin
               st_next.state = STALL_WAIT;
            end
         end
         STALL_WAIT: begin
            if (cycle_start || !stall_req) begin
               st_next.state = STALL_IDLE;
            end
         end
         default: begin
            st_next.state = STALL_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg.state <= STALL_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // Completion only on the phi1 start; only the CPU clock is held
   assign access_ok = !stall_req || cycle_start;
   assign cpu_clk_hold = stall_req && !cycle_start;
   assign stall_active = (st_reg.state == STALL_WAIT);

endmodule : scdac_stall_sync

// ### tb/scdac_top_assertions.sv
// Port checker for phase timing, stall and power of the converter
`timescale 1ns/10ps
module scdac_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic cpu_clk_hold,
   input wire scdac_pkg::scdac_analog_t analog_ctl
);
   import scdac_pkg::*;
   // Longest stall: one update cycle of 32 pclk at the bench rate
   localparam int STALL_MAX = 36;
   logic [7:0] hold_cnt_reg;
   logic [7:0] hold_cnt_next;

   // Length of the current CPU clock hold
   always_comb begin
      hold_cnt_next = cpu_clk_hold ? hold_cnt_reg + 8'h01 : 8'h00;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_cnt_reg <= 8'h00;
      end else begin
         hold_cnt_reg <= hold_cnt_next;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Phase shapes, column half period of 4 pclk
   a_phi2_width: assert property ($rose(analog_ctl.phi2) |->
      analog_ctl.phi2[*8] ##1 !analog_ctl.phi2) else $error("phi2 width");
   a_gap_before: assert property ($fell(analog_ctl.phi1) |->
      ##8 $rose(analog_ctl.phi2)) else $error("phi1 to phi2 gap");
   a_cycle_repeat: assert property ($fell(analog_ctl.phi2) |->
      ##8 $rose(analog_ctl.phi1)) else $error("cycle not repeated");
   // Roles of the phases and the bus sample switch
   a_phase_roles: assert property (
      (analog_ctl.autozero == analog_ctl.phi1 &&
       analog_ctl.output_valid == analog_ctl.phi2) ||
      (analog_ctl.autozero == analog_ctl.phi2 &&
       analog_ctl.output_valid == analog_ctl.phi1)) else $error("roles");
   a_sample_late: assert property ($rose(analog_ctl.sh_switch_closed) &&
      analog_ctl.phi2 && !analog_ctl.autozero |->
      $past(analog_ctl.phi2, 4) && !$past(analog_ctl.phi2, 5))
      else $error("sample not in late phi2");
   a_swap_hold: assert property (analog_ctl.phi2 && analog_ctl.autozero
      |-> analog_ctl.sh_switch_closed) else $error("hold not bypassed");
   // Stall handshake
   a_hold_ready: assert property (psel && penable |->
      cpu_clk_hold == !pready) else $error("hold and ready disagree");
   a_stall_end: assert property ($fell(cpu_clk_hold) |->
      ##[0:2] $rose(analog_ctl.phi1)) else $error("stall end off phi1");
   a_stall_bound: assert property (hold_cnt_reg <= STALL_MAX)
      else $error("stall too long");
   // Power and output routing
   a_power_drive: assert property (analog_ctl.outputs_driven ==
      (analog_ctl.stage_power != power_level_off)) else $error("drive");
   a_buffer_route: assert property (analog_ctl.out_buffer_enable ==
      (analog_ctl.output_bus_route_enable && analog_ctl.outputs_driven))
      else $error("buffer routing");
endmodule : scdac_assertions

bind scdac_top scdac_assertions chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pready(pready),
   .cpu_clk_hold(cpu_clk_hold), .analog_ctl(analog_ctl));

// ### tb/sc_dac_phase_update_control_tb.sv
// Self-checking bench of the converter control block
`timescale 1ns/10ps
`include "scdac_consts.svh"
module sc_dac_phase_update_control_tb;
   import scdac_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic cpu_clk_hold;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] col_clk_src;
   logic [1:0] col_cnt;
   scdac_analog_t analog_ctl;
   int fails, checked, waited;
   logic [7:0] vin [4] = '{8'hCA, 8'h4A, 8'h35, 8'h4A};

   scdac_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .col_clk_src(col_clk_src), .analog_ctl(analog_ctl),
      .cpu_clk_hold(cpu_clk_hold));

   // Bus clock
   always #2.5 pclk = ~pclk;
   // Column clock, one level change every 4 pclk, same on every source
   always @(posedge pclk) begin
      col_cnt <= col_cnt + 2'h1;
      if (col_cnt == 2'h3) col_clk_src <= ~col_clk_src;
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         fails++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   task automatic stop_test;
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test

   // One APB transfer; waits for ready under a bound
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      waited = 0;
      do begin
         @(posedge pclk);
         waited++;
      end while (pready !== 1'b1 && waited < 99);
      if (waited >= 99) fails++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Waits for the next rise of phi1
   task automatic wait_cyc;
      int n;
      n = 0;
      while (analog_ctl.phi1 !== 1'b0 && n < 99) begin
         @(negedge pclk);
         n++;
      end
      while (analog_ctl.phi1 !== 1'b1 && n < 99) begin
         @(negedge pclk);
         n++;
      end
      if (n >= 99) fails++;
   endtask : wait_cyc

   function automatic logic [31:0] code_now();
      return {24'h00_0000, analog_ctl.sign_negative,
              analog_ctl.msb_magnitude, analog_ctl.lsb_magnitude};
   endfunction : code_now

   task automatic t_reset;
      apb(1'b0, `SCDAC_CTRL_OFS, 32'h0000_0000);
      chk(rd, `SCDAC_CTRL_RST);
      @(negedge pclk);
      chk(32'(analog_ctl.outputs_driven), 32'h0000_0000);
      apb(1'b1, `SCDAC_CTRL_OFS, 32'h0000_3000);
      wait_cyc;
      wait_cyc;
      chk(32'(analog_ctl.outputs_driven), 32'h0000_0001);
      chk(code_now(), 32'h0000_0000);
   endtask : t_reset

   task automatic t_power;
      for (int p = 0; p < 4; p++) begin
         apb(1'b1, `SCDAC_CTRL_OFS, 32'(p) << `SCDAC_CTRL_PWR_LSB);
         @(negedge pclk);
         @(negedge pclk);
         chk(32'(analog_ctl.stage_power), 32'(p));
      end
      apb(1'b1, `SCDAC_CTRL_OFS, 32'h0000_0000);
      apb(1'b1, `SCDAC_VALUE_OFS, 32'h0000_0005);
      apb(1'b1, `SCDAC_CTRL_OFS, 32'h0000_3000);
      wait_cyc;
      wait_cyc;
      chk(code_now(), 32'h0000_0005);
   endtask : t_power

   // Each input format; value waits for the next update cycle
   task automatic t_format;
      logic [31:0] old, exp;
      old = 32'h0000_0005;
      for (int f = 0; f < 4; f++) begin
         exp = f[0] ? 32'h0000_004A : 32'h0000_00CA;
         apb(1'b1, `SCDAC_CTRL_OFS,
             32'h0000_3000 | (32'(f) << `SCDAC_CTRL_FMT_LSB));
         wait_cyc;
         apb(1'b1, `SCDAC_VALUE_OFS, {24'h00_0000, vin[f]});
         @(negedge pclk);
         chk(code_now(), old);
         apb(1'b0, `SCDAC_VALUE_OFS, 32'h0000_0000);
         chk(rd, exp);
         wait_cyc;
         @(negedge pclk);
         @(negedge pclk);
         chk(code_now(), exp);
         wait_cyc;
         chk(code_now(), exp);
         old = exp;
      end
   endtask : t_format

   // Synchronised write issued just after phi1 starts
   task automatic t_stall;
      logic [7:0] cnt;
      apb(1'b1, `SCDAC_CTRL_OFS, 32'h0000_3004);
      wait_cyc;
      // Hold and ready looked at while the write is stalled
      fork
         apb(1'b1, `SCDAC_VALUE_OFS, 32'h0000_0011);
         begin
            repeat (5) @(negedge pclk);
            chk(32'({cpu_clk_hold, pready}), 32'h0000_0002);
         end
      join
      chk(32'(waited > 20), 32'h0000_0001);
      @(negedge pclk);
      chk(code_now(), 32'h0000_004A);
      @(negedge pclk);
      chk(code_now(), 32'h0000_0011);
      chk(32'(cpu_clk_hold), 32'h0000_0000);
      // Status: powered, written, idle stall, both codes loaded
      apb(1'b0, `SCDAC_STATUS_OFS, 32'h0000_0000);
      chk(rd & 32'h00FF_FF1C, 32'h0011_1114);
      cnt = rd[`SCDAC_STAT_CNT_LSB +: 8];
      cnt = cnt + 8'h01;
      wait_cyc;
      apb(1'b0, `SCDAC_STATUS_OFS, 32'h0000_0000);
      chk(32'(rd[`SCDAC_STAT_CNT_LSB +: 8]), 32'(cnt));
   endtask : t_stall

   // Swapped and normal order with the bus route
   task automatic t_swap;
      apb(1'b1, `SCDAC_CTRL_OFS, 32'h0000_3003);
      wait_cyc;
      chk(32'({analog_ctl.autozero, analog_ctl.output_valid,
         analog_ctl.sh_switch_closed, analog_ctl.out_buffer_enable,
         analog_ctl.output_bus_route_enable}),
         32'h0000_000F);
      repeat (18) @(negedge pclk);
      chk(32'({analog_ctl.autozero, analog_ctl.output_valid,
         analog_ctl.sh_switch_closed}), 32'h0000_0005);
      apb(1'b1, `SCDAC_CTRL_OFS, 32'h0000_0002);
      wait_cyc;
      chk(32'({analog_ctl.autozero, analog_ctl.output_valid,
         analog_ctl.sh_switch_closed, analog_ctl.out_buffer_enable,
         analog_ctl.output_bus_route_enable}),
         32'h0000_0011);
      repeat (21) @(negedge pclk);
      chk(32'({analog_ctl.autozero, analog_ctl.output_valid,
         analog_ctl.sh_switch_closed}), 32'h0000_0003);
   endtask : t_swap

   // Unmapped place is refused and leaves the registers alone
   task automatic t_unmapped;
      apb(1'b1, 12'h0C0, 32'hFFFF_FFFF);
      chk(32'(err), 32'h0000_0001);
      apb(1'b0, 12'h0C0, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, `SCDAC_CTRL_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0002);
   endtask : t_unmapped

   // Hang guard
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      stop_test;
   end

   // Main sequence with a second reset in mid-run
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      col_clk_src = 4'h0;
      col_cnt = 2'h0;
      fails = 0;
      checked = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_power;
      t_format;
      t_stall;
      t_swap;
      t_unmapped;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      stop_test;
   end
endmodule : sc_dac_phase_update_control_tb
